// *** tb_urxf_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_urxf_top;
  import urxf_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [2:0] adr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wreq;
  logic rx;
  logic irq;
  int fails = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h9DB7;
  logic [8:0] q [5];
  logic [8:0] w;
  logic p;

  always #5 CLK = ~CLK;

  urxf_top urxf_top_i (.CLK(CLK), .RST(RST), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .RX_PIN(rx), .IRQ(irq));
  urxf_line_model urxf_line_model_i (.clk(CLK), .line(rx));

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // parity bit a correct sender puts after seven data bits
  function automatic logic par_bit(input logic [6:0] d, input logic [1:0] typ);
    case (typ)
      2'h0: return ~^d;
      2'h1: return ^d;
      2'h2: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // hold the request until waitrequest is sampled low, then release it
  task automatic bus(input logic [2:0] a, input logic w_en, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge CLK);
    adr <= a;
    wdat <= d;
    rd <= ~w_en;
    wr <= w_en;
    do begin
      @(posedge CLK);
    end while (wreq !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic chk(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    check(what, e & m, r & m);
  endtask

  task automatic tx(input logic [8:0] v, input int nb, input logic [1:0] st, input int ns);
    urxf_line_model_i.send(v, nb, st, ns, 16, -1);
    repeat (2) @(posedge CLK);
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    chk(REG_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
    chk(REG_BAUD, 32'hFFFFFFFF, 32'h000F, "baud reset");
    chk(REG_STATUS, 32'h3D, 32'h0, "status reset");
    // one byte lane only: just the trigger field lands
    be <= 4'h2;
    bus_wr(REG_CTRL, 32'hFFFFFFFF);
    be <= 4'hF;
    chk(REG_CTRL, 32'hFFFFFFFF, 32'h300, "byte lanes");
    bus_wr(3'h5, 32'hFFFFFFFF);
    chk(3'h5, 32'hFFFFFFFF, 32'h0, "unmapped");
    bus_wr(REG_BAUD, 32'h0);
    tx(9'h0A5, 8, 2'h3, 1);
    chk(REG_COUNT, 32'h7, 32'h0, "count while off");
    // level irq at two words, then a fifth word overruns a full fifo
    bus_wr(REG_CTRL, 32'h1C1);
    for (int k = 0; k < 5; k++) begin
      seed = rnd(seed);
      q[k] = {1'b0, seed[7:0]};
      if (k == 3) q[k] = 9'h0FF;
      if (k == 1) begin
        fork
          tx(q[k], 8, 2'h3, 1);
          begin
            repeat (60) @(posedge CLK);
            chk(REG_STATUS, 32'h1 << SB_IDLE, 32'h0, "idle in frame");
          end
        join
      end else begin
        tx(q[k], 8, 2'h3, 1);
      end
      chk(REG_COUNT, 32'h7, (k < 4) ? k + 1 : 4, "count");
      check("irq level", {31'h0, k >= 1}, {31'h0, irq});
    end
    chk(REG_STATUS, 32'h7, 32'h7, "status overrun");
    bus_wr(REG_CTRL, 32'h041);
    repeat (3) @(posedge CLK);
    check("irq overrun", 32'h1, {31'h0, irq});
    for (int k = 0; k < 4; k++) begin
      chk(REG_STATUS, 32'h1, 32'h1, "avail");
      chk(REG_DATA, 32'hFF, {23'h0, q[k]}, "fifo word");
    end
    chk(REG_STATUS, 32'h5, 32'h0, "flags cleared");
    check("irq cleared", 32'h0, {31'h0, irq});
    // every parity type, once correct and once wrong
    for (int t = 0; t < 4; t++) begin
      for (int bad = 0; bad < 2; bad++) begin
        bus_wr(REG_CTRL, 32'h005 | (t << 3));
        seed = rnd(seed);
        p = par_bit(seed[6:0], t[1:0]) ^ bad[0];
        w = {1'b0, p, seed[6:0]};
        tx(w, 8, 2'h3, 1);
        chk(REG_STATUS, 32'h1 << SB_PARITY_ERROR_FLAG, bad << SB_PARITY_ERROR_FLAG, "parity error");
        chk(REG_DATA, 32'hFF, {23'h0, w}, "parity word");
      end
    end
    // nine-bit word
    bus_wr(REG_CTRL, 32'h003);
    seed = rnd(seed);
    w = seed[8:0] | 9'h100;
    tx(w, 9, 2'h3, 1);
    chk(REG_STATUS, 32'h1 << SB_NINTH, 32'h1 << SB_NINTH, "ninth bit");
    chk(REG_DATA, 32'hFF, {24'h0, w[7:0]}, "nine bit word");
    // two stop bits, second one low, then a clean frame
    bus_wr(REG_CTRL, 32'h021);
    tx(9'h03C, 8, 2'h1, 2);
    urxf_line_model_i.hold(1'b1, 32);
    tx(9'h0C3, 8, 2'h3, 2);
    chk(REG_STATUS, 32'h1 << SB_FRAMING_ERROR_FLAG, 32'h1 << SB_FRAMING_ERROR_FLAG, "second stop low");
    chk(REG_DATA, 32'hFF, 32'h3C, "framed word");
    chk(REG_STATUS, 32'h1 << SB_FRAMING_ERROR_FLAG, 32'h0, "good stops");
    chk(REG_DATA, 32'hFF, 32'hC3, "good word");
    // long break: one zero word only, then idle once the line is high
    bus_wr(REG_CTRL, 32'h001);
    urxf_line_model_i.hold(1'b0, 480);
    urxf_line_model_i.hold(1'b1, 32);
    chk(REG_COUNT, 32'h7, 32'h1, "break count");
    chk(REG_STATUS, 32'h13, 32'h13, "break status");
    chk(REG_DATA, 32'hFF, 32'h0, "break word");
    // a one-clock glitch on a data bit: noise flagged, word still stored
    urxf_line_model_i.send(9'h05A, 8, 2'h3, 1, 16, 3);
    repeat (2) @(posedge CLK);
    chk(REG_STATUS, 32'h9, 32'h9, "noise status");
    chk(REG_DATA, 32'hFF, 32'h5A, "noisy word");
    chk(REG_STATUS, 32'h1 << SB_NOISE, 32'h0, "noise cleared");
    // a low stop bit leaves a framing error, which a mid-run reset clears
    tx(9'h000, 8, 2'h0, 1);
    urxf_line_model_i.hold(1'b1, 32);
    chk(REG_STATUS, 32'h1 << SB_FRAMING_ERROR_FLAG, 32'h1 << SB_FRAMING_ERROR_FLAG, "low stop");
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    chk(REG_STATUS, 32'h3D, 32'h0, "status after reset");
    chk(REG_COUNT, 32'h7, 32'h0, "count after reset");
    give_verdict();
  end
endmodule // tb_urxf_top
`default_nettype wire

// *** urxf_line_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module urxf_line_model (
  // clock
  input wire logic clk,
  // serial line towards the receiver
  output logic line
);
  initial line = 1'b1;

  // start low, nb data bits lsb first, then ns stop bits taken from st[0] upwards;
  // frame bit gl gets a one-clock glitch, -1 for none
  task automatic send(input logic [8:0] w, input int nb, input logic [1:0] st, input int ns,
                      input int bclk, input int gl);
    logic b;
    for (int i = 0; i < 1 + nb + ns; i++) begin
      if (i == 0) begin
        b = 1'b0;
      end else if (i <= nb) begin
        b = w[i-1];
      end else begin
        b = st[i-nb-1];
      end
      @(posedge clk);
      line <= b;
      if (i == gl) begin
        // inverted over the middle vote sample only, so the majority still wins
        repeat (bclk / 2 + 1) @(posedge clk);
        line <= ~b;
        @(posedge clk);
        line <= b;
        repeat (bclk / 2 - 3) @(posedge clk);
      end else begin
        repeat (bclk - 1) @(posedge clk);
      end
    end
  endtask

  // plain level for a number of clocks, used for breaks and the high line after them
  task automatic hold(input logic v, input int clks);
    @(posedge clk);
    line <= v;
    repeat (clks - 1) @(posedge clk);
  endtask
endmodule // urxf_line_model
`default_nettype wire

// *** urxf_pkg.sv ***
`default_nettype none
package urxf_pkg;

  // register word indices on the avalon address (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_BAUD = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_COUNT = 3'h4;

  // uart_control_one fields
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam int CB_RX_ENABLE = 0;
  localparam int CB_NINE = 1;
  localparam int CB_PARITY_ENABLE = 2;
  localparam int CB_PTYP = 3;
  localparam int CB_STOP2 = 5;
  localparam int CB_RIE = 6;
  localparam int CB_LVLIE = 7;
  localparam int CB_TRIG = 8;

  // baud divisor: one oversample tick every divisor + 1 clocks
  localparam int BAUD_W = 16;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h000F;

  // uart_status_reg fields
  localparam int SB_AVAIL = 0;
  localparam int SB_IDLE = 1;
  localparam int SB_OVR = 2;
  localparam int SB_NOISE = 3;
  localparam int SB_FRAMING_ERROR_FLAG = 4;
  localparam int SB_PARITY_ERROR_FLAG = 5;
  localparam int SB_NINTH = 6;
  localparam int SB_IRQ = 7;

  // fifo entry layout and depth
  localparam int WORD_W = 9;
  localparam int EB_FRAMING_ERROR_FLAG = 9;
  localparam int EB_PARITY_ERROR_FLAG = 10;
  localparam int ENT_W = 11;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL = 3'h4;

  // bit counting and oversampling
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] VOTE_P0 = 4'h7;
  localparam logic [3:0] VOTE_P1 = 4'h8;
  localparam logic [3:0] VOTE_P2 = 4'h9;

  typedef enum logic [1:0] {
    PAR_ODD = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_MARK = 2'h2,
    PAR_SPACE = 2'h3
  } urxf_par_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_START = 3'h1,
    S_DATA = 3'h3,
    S_STOP = 3'h2,
    S_STOP2 = 3'h6,
    S_BRKW = 3'h4
  } urxf_state_t;

  function automatic logic [31:0] urxf_be_merge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// *** urxf_recover.sv ***
`timescale 1ns/100ps
`default_nettype none
module urxf_recover
  import urxf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_pin,
  input wire logic run,
  input wire logic [BAUD_W-1:0] divisor,
  output logic tick,
  output logic bit_stb,
  output logic bit_val,
  output logic bit_noise
);

  logic [BAUD_W-1:0] presc_r;
  logic [3:0] phase_r;
  logic s0_r, s1_r, s2_r;

  assign tick = (presc_r == divisor);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_r <= '0;
    end else if (tick || presc_r > divisor) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 16'h0001;
    end
  end

  // sixteen ticks per bit; phase held at zero outside a frame so a start edge realigns it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= 4'h0;
    end else if (!run) begin
      phase_r <= 4'h0;
    end else if (tick) begin
      phase_r <= phase_r + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s0_r <= 1'b1;
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else if (run && tick) begin
      if (phase_r == VOTE_P0) s0_r <= rx_pin;
      if (phase_r == VOTE_P1) s1_r <= rx_pin;
      if (phase_r == VOTE_P2) s2_r <= rx_pin;
    end
  end

  assign bit_stb = run && tick && (phase_r == OVS_LAST);
  assign bit_val = (s0_r & s1_r) | (s0_r & s2_r) | (s1_r & s2_r);
  assign bit_noise = !((s0_r == s1_r) && (s1_r == s2_r));

  ovs_spacing_a: assert property (@(posedge clk) disable iff (rst)
    bit_stb |=> !bit_stb [*8]) else $error("bit strobes closer than a bit period");
  vote_major_a: assert property (@(posedge clk) disable iff (rst)
    (bit_stb && s0_r == s1_r) |-> (bit_val == s0_r) && (bit_noise == (s2_r != s0_r)))
    else $error("majority vote wrong");

endmodule // urxf_recover
`default_nettype wire

// *** urxf_top.sv ***
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - nine-bit mode keeps the received top bit as the ninth status bit
// - recovery runs at sixteen ticks per bit, shifter once per bit
// - each bit is the majority of three pin samples
// - words are assembled least significant bit first
// - four-word fifo plus one word in the shift register
// - after the stop bit the word enters the fifo when room exists
// - word finished on a full fifo with no data-read pop in the same cycle sets overrun, fifo kept, word lost
// - setting receive enable starts the hunt for a start bit
// - available flag while fifo holds data; count register shows the fill
// - interrupt when enabled and fill reaches the trigger level
// - overrun and noise clear by status read then data read; available drops when data reads empty the fifo
// - a break is a framing error, loads zeros, sets available and idle
// - after a break wait for a high line before hunting again
// - idle is low from start detection to stop bit, high otherwise
// - overrun also raises the interrupt when enabled
// - noise sets its flag with the word, which is still stored
// - low stop bit sets framing error; with two stops both must be high
// - parity mismatch of selected type sets parity error, word kept
// - framing and parity error flags clear on reset
// - two-bit parity type picks odd, even, mark or space
module urxf_top
  import urxf_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // serial line and request
  input wire logic RX_PIN,
  output logic IRQ
);

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  logic ack_r;
  logic acc_rd, acc_wr;
  logic [CTRL_W-1:0] ctrl_r;
  logic [BAUD_W-1:0] baud_r;
  logic [31:0] ctrl_wr, baud_wr, rd_mux;
  logic rx_enable, nine_bit_select, parity_enable, two_stop, rx_irq_enable, rx_level_irq_enable;
  logic [1:0] parity_type_sel;
  logic [2:0] trig_cnt;
  urxf_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [WORD_W-1:0] rx_shift_reg;
  logic noise_acc_r, noise_now;
  logic run, tick, bit_stb, bit_val, bit_noise;
  logic frame_done, frame_framing_error_flag, frame_parity_error_flag;
  logic [WORD_W-1:0] word;
  logic [ENT_W-1:0] tx_rx_data_fifo [FIFO_DEPTH];
  logic [1:0] wr_ptr_r, rd_ptr_r;
  logic [2:0] rx_fill_count;
  logic push, pop, room;
  logic [ENT_W-1:0] head;
  logic status_seen_r, clr_seq;
  logic rd_avail_r;
  logic overrun_flag, noise_flag, rx_idle_flag, rx_avail_flag;
  logic irq_nxt;

  // a read that completes at this edge on one register index
  function automatic logic rd_done(input logic acc, input logic [2:0] a, input logic [2:0] idx);
    return acc && (a == idx);
  endfunction

  assign rx_enable = ctrl_r[CB_RX_ENABLE];
  assign nine_bit_select = ctrl_r[CB_NINE];
  assign parity_enable = ctrl_r[CB_PARITY_ENABLE];
  assign parity_type_sel = ctrl_r[CB_PTYP +: 2];
  assign two_stop = ctrl_r[CB_STOP2];
  assign rx_irq_enable = ctrl_r[CB_RIE];
  assign rx_level_irq_enable = ctrl_r[CB_LVLIE];
  assign trig_cnt = {1'b0, ctrl_r[CB_TRIG +: 2]} + 3'h1;

  // avalon handshake: every access waits exactly one cycle, then completes
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
  assign acc_rd = AVS_READ & ack_r;
  assign acc_wr = AVS_WRITE & ack_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
    end
  end

  assign ctrl_wr = urxf_be_merge(32'(ctrl_r), AVS_WRITEDATA, AVS_BYTEENABLE);
  assign baud_wr = urxf_be_merge(32'(baud_r), AVS_WRITEDATA, AVS_BYTEENABLE);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= CTRL_RST;
      baud_r <= BAUD_RST;
    end else if (acc_wr) begin
      if (AVS_ADDRESS == REG_CTRL) ctrl_r <= ctrl_wr[CTRL_W-1:0];
      if (AVS_ADDRESS == REG_BAUD) baud_r <= baud_wr[BAUD_W-1:0];
    end
  end

  assign head = tx_rx_data_fifo[rd_ptr_r];
  assign rx_avail_flag = (rx_fill_count != 3'h0);
  assign rx_idle_flag = (state_r == S_IDLE) || (state_r == S_BRKW);

  // error flags follow the word at the head, so they must be read before it is popped
  always_comb begin
    rd_mux = 32'h00000000;
    case (AVS_ADDRESS)
      REG_CTRL: rd_mux = 32'(ctrl_r);
      REG_BAUD: rd_mux = 32'(baud_r);
      REG_STATUS: begin
        rd_mux[SB_AVAIL] = rx_avail_flag;
        rd_mux[SB_IDLE] = rx_idle_flag;
        rd_mux[SB_OVR] = overrun_flag;
        rd_mux[SB_NOISE] = noise_flag;
        rd_mux[SB_FRAMING_ERROR_FLAG] = rx_avail_flag && head[EB_FRAMING_ERROR_FLAG];
        rd_mux[SB_PARITY_ERROR_FLAG] = rx_avail_flag && head[EB_PARITY_ERROR_FLAG];
        rd_mux[SB_NINTH] = rx_avail_flag && nine_bit_select && head[WORD_W-1];
        rd_mux[SB_IRQ] = IRQ;
      end
      REG_DATA: rd_mux = rx_avail_flag ? 32'(head[WORD_W-2:0]) : 32'h00000000;
      REG_COUNT: rd_mux = 32'(rx_fill_count);
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= 32'h00000000;
      rd_avail_r <= 1'b0;
    end else if (AVS_READ && !ack_r) begin
      AVS_READDATA <= rd_mux;
      // the pop follows this answer, so a word pushed before the next edge is not lost
      rd_avail_r <= rx_avail_flag;
    end
  end

  // receive state machine; dropping the enable abandons any frame in flight
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= S_IDLE;
    end else if (!rx_enable) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE: if (tick && !RX_PIN) state_r <= S_START;
        S_START: if (bit_stb) state_r <= bit_val ? S_IDLE : S_DATA;
        S_DATA: begin
          if (bit_stb && bit_cnt_r == (nine_bit_select ? LAST_BIT9 : LAST_BIT8)) begin
            state_r <= S_STOP;
          end
        end
        S_STOP: begin
          if (bit_stb) begin
            if (!bit_val) begin
              state_r <= S_BRKW;
            end else begin
              state_r <= two_stop ? S_STOP2 : S_IDLE;
            end
          end
        end
        S_STOP2: if (bit_stb) state_r <= bit_val ? S_IDLE : S_BRKW;
        S_BRKW: if (tick && RX_PIN) state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  assign run = (state_r == S_START) || (state_r == S_DATA) ||
               (state_r == S_STOP) || (state_r == S_STOP2);

  urxf_recover urxf_recover_i (
    .clk(CLK),
    .rst(RST),
    .rx_pin(RX_PIN),
    .run(run),
    .divisor(baud_r),
    .tick(tick),
    .bit_stb(bit_stb),
    .bit_val(bit_val),
    .bit_noise(bit_noise)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bit_cnt_r <= 4'h0;
      rx_shift_reg <= '0;
    end else if (state_r == S_START) begin
      bit_cnt_r <= 4'h0;
    end else if (state_r == S_DATA && bit_stb) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      rx_shift_reg <= {bit_val, rx_shift_reg[WORD_W-1:1]};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      noise_acc_r <= 1'b0;
    end else if (state_r == S_IDLE) begin
      noise_acc_r <= 1'b0;
    end else if (bit_stb) begin
      noise_acc_r <= noise_acc_r | bit_noise;
    end
  end

  // the parity bit, when enabled, is the last bit shifted and sits at the top of the word
  assign word = nine_bit_select ? rx_shift_reg : {1'b0, rx_shift_reg[WORD_W-1:1]};
  assign frame_done = bit_stb && (((state_r == S_STOP) && (!bit_val || !two_stop)) ||
                      (state_r == S_STOP2));
  assign frame_framing_error_flag = !bit_val;
  assign noise_now = noise_acc_r | bit_noise;

  always_comb begin
    frame_parity_error_flag = 1'b0;
    if (parity_enable) begin
      unique case (urxf_par_t'(parity_type_sel))
        PAR_ODD: frame_parity_error_flag = !(^word);
        PAR_EVEN: frame_parity_error_flag = ^word;
        PAR_MARK: frame_parity_error_flag = !rx_shift_reg[WORD_W-1];
        PAR_SPACE: frame_parity_error_flag = rx_shift_reg[WORD_W-1];
      endcase
    end
  end

  // a pop frees the slot in the same edge, so a full fifo still takes the word
  assign pop = rd_done(acc_rd, AVS_ADDRESS, REG_DATA) && rd_avail_r;
  assign room = (rx_fill_count != FIFO_FULL) || pop;
  assign push = frame_done && room;

  always_ff @(posedge CLK) begin
    if (push) begin
      tx_rx_data_fifo[wr_ptr_r] <= {frame_parity_error_flag, frame_framing_error_flag, word};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      rx_fill_count <= 3'h0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 2'h1;
      if (pop) rd_ptr_r <= rd_ptr_r + 2'h1;
      if (push && !pop) begin
        rx_fill_count <= rx_fill_count + 3'h1;
      end else if (pop && !push) begin
        rx_fill_count <= rx_fill_count - 3'h1;
      end
    end
  end

  // clear sequence: a status read arms, the next data read clears
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_seen_r <= 1'b0;
    end else if (rd_done(acc_rd, AVS_ADDRESS, REG_STATUS)) begin
      status_seen_r <= 1'b1;
    end else if (rd_done(acc_rd, AVS_ADDRESS, REG_DATA)) begin
      status_seen_r <= 1'b0;
    end
  end

  assign clr_seq = rd_done(acc_rd, AVS_ADDRESS, REG_DATA) && status_seen_r;

  // a new event in the clearing cycle wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      overrun_flag <= 1'b0;
    end else if (frame_done && !room) begin
      overrun_flag <= 1'b1;
    end else if (clr_seq) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      noise_flag <= 1'b0;
    end else if (push && noise_now) begin
      noise_flag <= 1'b1;
    end else if (clr_seq) begin
      noise_flag <= 1'b0;
    end
  end

  assign irq_nxt = rx_irq_enable && ((rx_level_irq_enable && rx_fill_count >= trig_cnt) ||
                   overrun_flag);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_nxt;
    end
  end

  fifo_cap_a: assert property (rx_fill_count <= FIFO_FULL)
    else $error("fifo fill above four");
  store_word_a: assert property ((frame_done && room && !pop) |=>
    rx_fill_count == $past(rx_fill_count) + 3'h1) else $error("word not stored");
  overrun_set_a: assert property ((frame_done && !room) |=>
    overrun_flag && rx_fill_count == FIFO_FULL) else $error("overrun not flagged");
  idle_low_a: assert property ((state_r == S_START) |-> !rx_idle_flag)
    else $error("idle high inside a frame");
  break_wait_a: assert property ((state_r == S_BRKW && !RX_PIN && rx_enable) |=>
    state_r == S_BRKW) else $error("low line left break wait");
  stop_low_a: assert property ((state_r == S_STOP && bit_stb && !bit_val && rx_enable) |=>
    state_r == S_BRKW ##0 rx_idle_flag) else $error("low stop bit not a framing error");
  level_irq_a: assert property ((rx_irq_enable && rx_level_irq_enable &&
    rx_fill_count >= trig_cnt) |=> IRQ) else $error("trigger level without request");
  ovr_irq_a: assert property ((rx_irq_enable && overrun_flag) |=> IRQ)
    else $error("overrun without request");
  clear_seq_a: assert property ((clr_seq && !frame_done) |=> !overrun_flag && !noise_flag)
    else $error("clear sequence failed");
  hunt_off_a: assert property (!rx_enable |=> state_r == S_IDLE)
    else $error("receiver active while disabled");
  noise_set_a: assert property ((push && noise_now) |=> noise_flag && rx_avail_flag)
    else $error("noisy word not flagged");
  avail_push_a: assert property (push |=> rx_avail_flag)
    else $error("available flag low after a store");
  shift_lsb_a: assert property ((state_r == S_DATA && bit_stb) |=>
    rx_shift_reg[WORD_W-1] == $past(bit_val)) else $error("bit not shifted in at the top");
  empty_read_a: assert property ((AVS_READ && !ack_r && AVS_ADDRESS == REG_DATA &&
    !rx_avail_flag) |=> !pop) else $error("pop of a word never returned");
  ovr_keep_a: assert property ((frame_done && !room) |=> wr_ptr_r == $past(wr_ptr_r))
    else $error("full fifo written on overrun");
  stop_two_a: assert property ((two_stop && state_r == S_STOP && bit_stb && bit_val &&
    rx_enable) |=> state_r == S_STOP2) else $error("second stop bit skipped");
  false_start_a: assert property ((state_r == S_START && bit_stb && bit_val &&
    rx_enable) |=> state_r == S_IDLE) else $error("false start not dropped");
  trig_range_a: assert property ((trig_cnt >= 3'h1) && (trig_cnt <= FIFO_FULL))
    else $error("trigger level out of range");

endmodule // urxf_top
`default_nettype wire
